// *** rtl/dac_channel.sv ***
/*
 One DAC channel: input register, DAC register and new-data flag.
 Assumes commands from the control logic, at most one force per cycle.
*/
`default_nettype none

module dac_channel (
   // Clock and reset
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   input  wire logic [15:0]           resetCode,
   // Command from the control logic: frame decoder, clear or load strobe
   input  wire dual_dac_pkg::chanCmd_t cmd,
   // Channel state
   output logic [15:0]                dacCode,
   output logic                       pending
);

   dual_dac_pkg::chanState_t s;
   dual_dac_pkg::chanState_t next_s;

   always_comb begin
      next_s = s;
      if (cmd.preset) begin
         next_s.inputCode = cmd.value;
         next_s.dacCode   = cmd.value;
         next_s.pending   = 1'b0;
      end else begin
         if (cmd.writeIn) begin
            next_s.inputCode = cmd.value;
            next_s.pending   = 1'b1;
         end
         // Write and update together bypass the old input code
         if (cmd.update) begin
            next_s.dacCode = cmd.writeIn ? cmd.value : s.inputCode;
            next_s.pending = 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s.inputCode <= resetCode;
         s.dacCode   <= resetCode;
         s.pending   <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   assign dacCode = s.dacCode;
   assign pending = s.pending;

endmodule

`default_nettype wire

// *** rtl/dual_dac_defs.svh ***
/*
 Constants of the dual DAC serial control logic: frame layout,
 command and address codes, codes and reset values.
 Assumes inclusion by bare name from the rtl files.
*/
`ifndef DUAL_DAC_DEFS_SVH
`define DUAL_DAC_DEFS_SVH

// Frame layout
`define FRAME_BITS      32
`define LAST_BIT_IDX    6'h1f
`define CMD_MSB         27
`define CMD_LSB         24
`define ADDR_MSB        23
`define ADDR_LSB        20
`define DATA_MSB        19
`define DATA_LSB        4
`define PD_MODE_MSB     5
`define PD_MODE_LSB     4
`define SEL_MSB         1
`define SEL_LSB         0
`define CHAIN_BIT       0

// Commands
`define CMD_WRITE_IN    4'h0
`define CMD_UPDATE      4'h1
`define CMD_WRITE_ALL   4'h2
`define CMD_WRITE_UPD   4'h3
`define CMD_POWER       4'h4
`define CMD_CLEAR_CODE  4'h5
`define CMD_STROBE_MASK 4'h6
`define CMD_RESET       4'h7
`define CMD_CHAIN       4'h8

// Channel addresses
`define ADDR_A          4'h0
`define ADDR_B          4'h1
`define ADDR_ALL        4'hf

// Codes and selections
`define CODE_ZERO       16'h0000
`define CODE_MID        16'h8000
`define CODE_FULL       16'hffff
`define CLEAR_SEL_ZERO  2'h0
`define CLEAR_SEL_MID   2'h1
`define CLEAR_SEL_FULL  2'h2
`define PD_NORMAL       2'h0

// Reset values
`define CLEAR_CODE_RESET  2'h0
`define STROBE_MASK_RESET 2'h0
`define CHAIN_RESET       1'h1

`endif

// *** rtl/dual_dac_pkg.sv ***
/*
 Types of the dual DAC serial control logic.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package dual_dac_pkg;

   typedef enum logic [1:0] {
      FRAME_IDLE  = 2'h0,
      FRAME_SHIFT = 2'h1,
      FRAME_DONE  = 2'h3
   } frameState_t;

   typedef struct packed {
      logic        writeIn;
      logic        update;
      logic        preset;
      logic [15:0] value;
   } chanCmd_t;

   typedef struct packed {
      logic [15:0] inputCode;
      logic [15:0] dacCode;
      logic        pending;
   } chanState_t;

   typedef struct packed {
      frameState_t state;
      logic [31:0] shift;
      logic [5:0]  bitCount;
      logic        sclkPrev;
      logic        syncPrev;
      logic        clearPrev;
      logic        lockPrev;
      logic        serialOut;
      logic [1:0]  clearCode;
      logic [1:0]  strobeMask;
      logic        chainEnable;
      logic [1:0]  powerDown;
      logic [1:0]  pdMode;
   } ctlState_t;

endpackage

`default_nettype wire

// *** rtl/dual_dac_serial_control.sv ***
/*
 Serial control logic of a dual voltage-output DAC: frame receiver,
 command decoder, clear, load strobe, power-down and lockout.
 Assumes all pins are synchronous to clock and the serial clock is
 well below half the system clock rate.
*/
`default_nettype none
`include "dual_dac_defs.svh"

// How it works
// - Load strobe low copies every unmasked channel with new data to its DAC register.
// - Strobe is level sensitive, so holding it low keeps working.
// - Falling frame sync arms the shift register for a new frame.
// - One data bit is taken on each of the next 32 serial clock falls.
// - Frame sync rising before the 32nd fall discards the frame.
// - Reset sets both channels to zero or midscale per the level strap.
// - Serial output shows the shift register, for chaining or readback.
// - Serial output changes on rising serial clock; far end samples on fall.
// - Clear acts on its falling edge regardless of the serial clock.
// - Load strobe is ignored while clear is low.
// - Clear loads input and DAC registers with the selected clear code.
// - Clear code selects zero scale after reset.
// - Lockout high allows software power-down commands.
// - Lockout low refuses any software power-down.
// - Lockout falling powers channels up with their held DAC code.
// - The shift register is 32 bits, loaded on serial clock falls.
// - Frame: four ignored, command, address, data, trailing bits that select for clear code, mask, power and chain.
// - Command executes on the 32nd fall whatever frame sync does after.
// - Command codes decode write, update, power, clear, mask, reset, chain.
// - Address 0000 is A, 0001 is B, 1111 both; others select nothing.
module dual_dac_serial_control (
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         rst_n,
   // Serial link
   input  wire logic         frameSync_n,
   input  wire logic         serialClock,
   input  wire logic         serialIn,
   output logic              serial_out,
   // Control pins
   input  wire logic         load_strobe_n,
   input  wire logic         async_clear_n,
   input  wire logic         powerdown_lockout_n,
   input  wire logic         powerUpMid,
   // Toward the analog core
   output logic [15:0]       dacCodeA,
   output logic [15:0]       dacCodeB,
   output logic [1:0]        channelPowerDown,
   output logic [1:0]        powerDownMode
);

   ////////////////////////////////////////////////////////////////////////
   // Edges and frame decode

   dual_dac_pkg::ctlState_t s;
   dual_dac_pkg::ctlState_t next_s;
   dual_dac_pkg::chanCmd_t  chanCmd [2];

   logic        sclkFall;
   logic        sclkRise;
   logic        syncFall;
   logic        syncRise;
   logic        clearFall;
   logic        lockFall;
   logic        shiftEdge;
   logic        exec;
   logic [31:0] frame;
   logic [3:0]  cmd;
   logic [3:0]  addr;
   logic [15:0] data;
   logic [1:0]  addrSel;
   logic [1:0]  pdSel;
   logic [1:0]  pdModeReq;
   logic [15:0] clearValue;
   logic [15:0] resetCode;
   logic [15:0] dacCode [2];
   logic [1:0]  pending;
   logic        strobeActive;

   assign sclkFall = s.sclkPrev & ~serialClock;
   assign sclkRise = ~s.sclkPrev & serialClock;
   assign syncFall = s.syncPrev & ~frameSync_n;
   assign syncRise = ~s.syncPrev & frameSync_n;
   assign clearFall = s.clearPrev & ~async_clear_n;
   assign lockFall  = s.lockPrev & ~powerdown_lockout_n;

   assign shiftEdge = (s.state == dual_dac_pkg::FRAME_SHIFT) & sclkFall
                      & ~frameSync_n & ~syncFall;
   assign exec      = shiftEdge & (s.bitCount == `LAST_BIT_IDX);

   assign frame = {s.shift[30:0], serialIn};
   assign cmd   = frame[`CMD_MSB:`CMD_LSB];
   assign addr  = frame[`ADDR_MSB:`ADDR_LSB];
   assign data  = frame[`DATA_MSB:`DATA_LSB];
   assign pdSel     = frame[`SEL_MSB:`SEL_LSB];
   assign pdModeReq = frame[`PD_MODE_MSB:`PD_MODE_LSB];

   // Reserved addresses select no channel
   always_comb begin
      case (addr)
         `ADDR_A:   addrSel = 2'h1;
         `ADDR_B:   addrSel = 2'h2;
         `ADDR_ALL: addrSel = 2'h3;
         default:   addrSel = 2'h0;
      endcase
   end

   always_comb begin
      case (s.clearCode)
         `CLEAR_SEL_MID:  clearValue = `CODE_MID;
         `CLEAR_SEL_FULL: clearValue = `CODE_FULL;
         default:       clearValue = `CODE_ZERO;
      endcase
   end

   assign resetCode = powerUpMid ? `CODE_MID : `CODE_ZERO;

   // Level sensitive, so a strobe tied low updates on every new write to an unmasked channel
   assign strobeActive = ~load_strobe_n & async_clear_n;

   ////////////////////////////////////////////////////////////////////////
   // Channel commands

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         chanCmd[i] = '0;
         chanCmd[i].value = data;
         if (clearFall) begin
            chanCmd[i].preset = 1'b1;
            chanCmd[i].value = clearValue;
         end else if (exec) begin
            case (cmd)
               `CMD_WRITE_IN: begin
                  chanCmd[i].writeIn = addrSel[i];
               end
               `CMD_UPDATE: begin
                  chanCmd[i].update = addrSel[i];
               end
               `CMD_WRITE_ALL: begin
                  chanCmd[i].writeIn = addrSel[i];
                  chanCmd[i].update  = 1'b1;
               end
               `CMD_WRITE_UPD: begin
                  chanCmd[i].writeIn = addrSel[i];
                  chanCmd[i].update  = addrSel[i];
               end
               `CMD_RESET: begin
                  chanCmd[i].preset = 1'b1;
                  chanCmd[i].value = resetCode;
               end
               default: begin
                  chanCmd[i].update = 1'b0;
               end
            endcase
         end else if (strobeActive && pending[i] && !s.strobeMask[i]) begin
            chanCmd[i].update = 1'b1;
         end
      end
   end

   for (genvar g = 0; g < 2; g++) begin : gen_chan
      dac_channel chan (
         .clock     (clock),
         .rst_n     (rst_n),
         .resetCode (resetCode),
         .cmd       (chanCmd[g]),
         .dacCode   (dacCode[g]),
         .pending   (pending[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Frame receiver and configuration

   always_comb begin
      next_s          = s;
      next_s.sclkPrev = serialClock;
      next_s.syncPrev = frameSync_n;
      next_s.clearPrev = async_clear_n;
      next_s.lockPrev  = powerdown_lockout_n;

      if (sclkRise) begin
         next_s.serialOut = s.chainEnable & s.shift[31];
      end

      if (syncFall) begin
         next_s.state    = dual_dac_pkg::FRAME_SHIFT;
         next_s.bitCount = 6'h0;
      end else begin
         case (s.state)
            dual_dac_pkg::FRAME_IDLE: begin
               next_s.state = dual_dac_pkg::FRAME_IDLE;
            end
            dual_dac_pkg::FRAME_SHIFT: begin
               if (syncRise) begin
                  next_s.state = dual_dac_pkg::FRAME_IDLE;
               end else if (shiftEdge) begin
                  next_s.shift    = frame;
                  next_s.bitCount = s.bitCount + 6'h1;
                  if (exec) begin
                     next_s.state = dual_dac_pkg::FRAME_DONE;
                  end
               end
            end
            dual_dac_pkg::FRAME_DONE: begin
               // Further clocks are ignored until the next frame
               if (frameSync_n) begin
                  next_s.state = dual_dac_pkg::FRAME_IDLE;
               end
            end
            default: begin
               next_s.state = dual_dac_pkg::FRAME_IDLE;
            end
         endcase
      end

      if (exec) begin
         case (cmd)
            `CMD_CLEAR_CODE: begin
               next_s.clearCode = frame[`SEL_MSB:`SEL_LSB];
            end
            `CMD_STROBE_MASK: begin
               next_s.strobeMask = frame[`SEL_MSB:`SEL_LSB];
            end
            `CMD_CHAIN: begin
               next_s.chainEnable = frame[`CHAIN_BIT];
            end
            `CMD_RESET: begin
               next_s.clearCode   = `CLEAR_CODE_RESET;
               next_s.strobeMask  = `STROBE_MASK_RESET;
               next_s.chainEnable = `CHAIN_RESET;
               next_s.powerDown   = 2'h0;
               next_s.pdMode      = `PD_NORMAL;
            end
            `CMD_POWER: begin
               for (int i = 0; i < 2; i++) begin
                  if (pdSel[i]) begin
                     if (pdModeReq == `PD_NORMAL) begin
                        next_s.powerDown[i] = 1'b0;
                     end else if (powerdown_lockout_n) begin
                        next_s.powerDown[i] = 1'b1;
                     end
                  end
               end
               if (pdModeReq == `PD_NORMAL || powerdown_lockout_n) begin
                  next_s.pdMode = pdModeReq;
               end
            end
            default: begin
               next_s.pdMode = s.pdMode;
            end
         endcase
      end

      // DAC registers are untouched, so the held code comes back
      if (lockFall) begin
         next_s.powerDown = 2'h0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s             <= '0;
         s.state       <= dual_dac_pkg::FRAME_IDLE;
         s.clearCode   <= `CLEAR_CODE_RESET;
         s.strobeMask  <= `STROBE_MASK_RESET;
         s.chainEnable <= `CHAIN_RESET;
         s.pdMode      <= `PD_NORMAL;
      end else begin
         s <= next_s;
      end
   end

   assign serial_out       = s.serialOut;
   assign dacCodeA         = dacCode[0];
   assign dacCodeB         = dacCode[1];
   assign channelPowerDown = s.powerDown;
   assign powerDownMode    = s.pdMode;

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   sequence sFrameArm;
      syncFall;
   endsequence

   sequence sLastBit;
      exec;
   endsequence

   sequence sAbort;
      s.state == dual_dac_pkg::FRAME_SHIFT && syncRise && !syncFall;
   endsequence

   AST_FRAME_ARM: assert property (
      sFrameArm |=> s.state == dual_dac_pkg::FRAME_SHIFT && s.bitCount == 6'h0)
      else $error("frame not armed after sync fall");

   AST_SHIFT_BIT: assert property (
      shiftEdge |=> s.shift[0] == $past(serialIn)
                    && s.shift[31:1] == $past(s.shift[30:0]))
      else $error("serial bit not shifted in");

   AST_ABORT: assert property (
      sAbort |=> s.state == dual_dac_pkg::FRAME_IDLE ##1 $stable(s.clearCode))
      else $error("aborted frame not discarded");

   AST_EXEC_LAST: assert property (
      sLastBit |-> s.bitCount == 6'h1f ##1 s.state == dual_dac_pkg::FRAME_DONE)
      else $error("frame end not on 32nd fall");

   AST_SERIAL_OUT: assert property (
      sclkRise && s.chainEnable |=> serial_out == $past(s.shift[31]))
      else $error("serial output wrong after rising clock");

   AST_SERIAL_HOLD: assert property (
      !sclkRise |=> $stable(serial_out))
      else $error("serial output moved without rising clock");

   AST_CLEAR: assert property (
      clearFall |=> dacCodeA == $past(clearValue) && dacCodeB == $past(clearValue))
      else $error("clear did not load clear code");

   AST_CLEAR_BLOCKS_STROBE: assert property (
      !async_clear_n && !clearFall && !exec |=> $stable(dacCodeA) && $stable(dacCodeB))
      else $error("DAC changed while clear held low");

   AST_STROBE: assert property (
      strobeActive && pending[0] && !s.strobeMask[0] && !exec && !clearFall
      |=> dacCodeA == $past(gen_chan[0].chan.s.inputCode) && !pending[0])
      else $error("load strobe did not update channel A");

   AST_LOCKOUT: assert property (
      !powerdown_lockout_n && s.powerDown == 2'h0 |=> s.powerDown == 2'h0)
      else $error("power-down entered under lockout");

   AST_LOCKOUT_WAKE: assert property (
      lockFall |=> channelPowerDown == 2'h0 && $stable(dacCodeA))
      else $error("lockout fall did not wake channels");

   AST_POWER_UP: assert property (
      disable iff (1'b0)
      $rose(rst_n) |-> dacCodeA == ($past(powerUpMid) ? `CODE_MID : `CODE_ZERO)
                       && s.clearCode == `CLEAR_CODE_RESET)
      else $error("wrong state after reset");

   AST_ADDR: assert property (
      exec && cmd == `CMD_WRITE_IN && addr == `ADDR_B
      |=> pending[1] && $stable(pending[0]))
      else $error("address decode wrong");

endmodule

`default_nettype wire

// *** tb/dual_dac_serial_control_test.sv ***
/*
 Self-checking bench of the dual DAC serial control logic.
 Assumes the host model drives the serial link; all other pins come from here.
*/
`default_nettype none
`include "dual_dac_defs.svh"

module dual_dac_serial_control_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic       clock, rst_n, load_strobe_n, async_clear_n, powerdown_lockout_n, powerUpMid;
   wire logic  frameSync_n, serialClock, serialIn, serial_out;
   wire logic [15:0] dacCodeA, dacCodeB;
   wire logic [1:0]  channelPowerDown, powerDownMode;
   int         n_mismatch, checks, cycles;
   logic [31:0] word;

   host_master host (.clock(clock), .frameSync_n(frameSync_n), .serialClock(serialClock),
      .serialIn(serialIn), .serial_out(serial_out));

   dual_dac_serial_control DUT (.clock(clock), .rst_n(rst_n), .frameSync_n(frameSync_n),
      .serialClock(serialClock), .serialIn(serialIn), .serial_out(serial_out),
      .load_strobe_n(load_strobe_n), .async_clear_n(async_clear_n),
      .powerdown_lockout_n(powerdown_lockout_n), .powerUpMid(powerUpMid), .dacCodeA(dacCodeA),
      .dacCodeB(dacCodeB), .channelPowerDown(channelPowerDown), .powerDownMode(powerDownMode));

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Run needs about 3600 cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         conclude();
      end
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [31:0] mk(input logic [3:0] cmd, input logic [3:0] addr,
                                      input logic [15:0] data, input logic [3:0] low);
      return {4'h0, cmd, addr, data, low};
   endfunction

   task automatic send(input logic [31:0] w, input int n = 32);
      host.sendFrame(w, n);
   endtask

   task automatic pulse();
      @(posedge clock) load_strobe_n <= 1'b0;
      repeat (2) @(posedge clock);
      load_strobe_n <= 1'b1;
      repeat (2) @(posedge clock);
   endtask

   task automatic codes(input logic [15:0] expA, input logic [15:0] expB);
      chk("dacCodeA", expA, dacCodeA);
      chk("dacCodeB", expB, dacCodeB);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic testReset(input logic mid);
      @(posedge clock) rst_n <= 1'b0;
      powerUpMid <= mid;
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      repeat (2) @(posedge clock);
      codes(mid ? `CODE_MID : `CODE_ZERO, mid ? `CODE_MID : `CODE_ZERO);
      chk("channelPowerDown", 2'h0, channelPowerDown);
      $display("test reset done");
   endtask

   task automatic testFrames();
      send(mk(`CMD_WRITE_UPD, `ADDR_A, 16'h1234, 4'h0));
      codes(16'h1234, `CODE_MID);
      send(mk(`CMD_WRITE_UPD, 4'h2, 16'h7777, 4'h0));
      codes(16'h1234, `CODE_MID);
      send(mk(`CMD_WRITE_UPD, `ADDR_B, 16'h4321, 4'h0), 31);
      codes(16'h1234, `CODE_MID);
      send(mk(`CMD_WRITE_UPD, `ADDR_B, 16'h4321, 4'h0));
      codes(16'h1234, 16'h4321);
      $display("test frames done");
   endtask

   task automatic testStrobe();
      send(mk(`CMD_WRITE_IN, `ADDR_ALL, 16'h2222, 4'h0));
      codes(16'h1234, 16'h4321);
      pulse();
      codes(16'h2222, 16'h2222);
      send(mk(`CMD_STROBE_MASK, `ADDR_A, 16'h0000, 4'h1));
      send(mk(`CMD_WRITE_IN, `ADDR_ALL, 16'h3333, 4'h0));
      pulse();
      codes(16'h2222, 16'h3333);
      send(mk(`CMD_UPDATE, `ADDR_A, 16'h0000, 4'h0));
      codes(16'h3333, 16'h3333);
      send(mk(`CMD_STROBE_MASK, `ADDR_A, 16'h0000, 4'h0));
      @(posedge clock) load_strobe_n <= 1'b0;
      send(mk(`CMD_WRITE_IN, `ADDR_B, 16'h5a5a, 4'h0));
      codes(16'h3333, 16'h5a5a);
      load_strobe_n <= 1'b1;
      send(mk(`CMD_WRITE_ALL, `ADDR_A, 16'h6666, 4'h0));
      codes(16'h6666, 16'h5a5a);
      $display("test strobe done");
   endtask

   task automatic testClear();
      @(posedge clock) async_clear_n <= 1'b0;
      repeat (2) @(posedge clock);
      codes(`CODE_ZERO, `CODE_ZERO);
      async_clear_n <= 1'b1;
      send(mk(`CMD_CLEAR_CODE, `ADDR_A, 16'h0000, 4'h2));
      @(posedge clock) async_clear_n <= 1'b0;
      repeat (2) @(posedge clock);
      codes(`CODE_FULL, `CODE_FULL);
      send(mk(`CMD_WRITE_IN, `ADDR_A, 16'h1111, 4'h0));
      pulse();
      codes(`CODE_FULL, `CODE_FULL);
      @(posedge clock) async_clear_n <= 1'b1;
      send(mk(`CMD_UPDATE, `ADDR_B, 16'h0000, 4'h0));
      pulse();
      codes(16'h1111, `CODE_FULL);
      $display("test clear done");
   endtask

   task automatic testPower();
      send(mk(`CMD_POWER, `ADDR_A, 16'h0001, 4'h3));
      chk("channelPowerDown", 2'h3, channelPowerDown);
      chk("powerDownMode", 2'h1, powerDownMode);
      @(posedge clock) powerdown_lockout_n <= 1'b0;
      repeat (2) @(posedge clock);
      chk("channelPowerDown", 2'h0, channelPowerDown);
      codes(16'h1111, `CODE_FULL);
      send(mk(`CMD_POWER, `ADDR_A, 16'h0002, 4'h3));
      chk("channelPowerDown", 2'h0, channelPowerDown);
      @(posedge clock) powerdown_lockout_n <= 1'b1;
      send(mk(`CMD_POWER, `ADDR_A, 16'h0003, 4'h2));
      chk("channelPowerDown", 2'h2, channelPowerDown);
      chk("powerDownMode", 2'h3, powerDownMode);
      send(mk(`CMD_POWER, `ADDR_A, 16'h0000, 4'h2));
      chk("channelPowerDown", 2'h0, channelPowerDown);
      chk("powerDownMode", 2'h0, powerDownMode);
      $display("test power done");
   endtask

   task automatic testChain();
      word = mk(`CMD_WRITE_IN, `ADDR_B, 16'hc3a5, 4'h9);
      send(word);
      send(mk(`CMD_WRITE_IN, `ADDR_B, 16'h0f0f, 4'h6));
      chk("rxWord", word, host.rxWord);
      send(mk(`CMD_CHAIN, `ADDR_A, 16'h0000, 4'h0));
      send(word);
      chk("rxWord", 32'h0, host.rxWord);
      send(mk(`CMD_CLEAR_CODE, `ADDR_A, 16'h0000, 4'h1));
      @(posedge clock) async_clear_n <= 1'b0;
      repeat (2) @(posedge clock);
      codes(`CODE_MID, `CODE_MID);
      async_clear_n <= 1'b1;
      send(mk(`CMD_WRITE_UPD, `ADDR_ALL, 16'h4444, 4'h0));
      codes(16'h4444, 16'h4444);
      send(mk(`CMD_RESET, `ADDR_A, 16'h0000, 4'h0));
      codes(`CODE_MID, `CODE_MID);
      $display("test chain done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n               = 1'b0;
      load_strobe_n       = 1'b1;
      async_clear_n       = 1'b1;
      powerdown_lockout_n = 1'b1;
      powerUpMid          = 1'b0;
      n_mismatch          = 0;
      checks              = 0;
      cycles              = 0;
      testReset(1'b0);
      testReset(1'b1);
      testFrames();
      testStrobe();
      testClear();
      testPower();
      testChain();
      conclude();
   end
endmodule

`default_nettype wire

// *** tb/host_master.sv ***
/*
 Host serial master model: frame sync, serial clock and data, readback.
 Assumes the bench calls sendFrame after reset is released.
*/
`default_nettype none

module host_master (
   // System clock
   input  wire logic  clock,
   // Serial link
   output var logic   frameSync_n,
   output var logic   serialClock,
   output var logic   serialIn,
   input  wire logic  serial_out
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [31:0] rxWord;

   initial begin
      frameSync_n = 1'b1;
      serialClock = 1'b0;
      serialIn    = 1'b0;
      rxWord      = 32'h0;
   end

   // Serial clock stands still outside frames
   task automatic sendFrame(input logic [31:0] word, input int nBits);
      @(posedge clock) frameSync_n <= 1'b0;
      repeat (2) @(posedge clock);
      for (int i = 0; i < nBits; i++) begin
         serialIn    <= word[31 - i];
         serialClock <= 1'b1;
         repeat (2) @(posedge clock);
         serialClock <= 1'b0;
         repeat (2) @(posedge clock);
         rxWord <= {rxWord[30:0], serial_out};
      end
      // Sync held low past the last bit on purpose
      repeat (8) @(posedge clock);
      frameSync_n <= 1'b1;
      // Released data line must not keep its last value
      serialIn    <= ~serialIn;
      repeat (3) @(posedge clock);
   endtask
endmodule

`default_nettype wire
